//--- core/wdt_pkg.sv
// wake-up detect timer package: register indices, fields, reset values, timing
// assumes the register index is the printed offset; byte address is four times it
package wdt_pkg;

  // ----------------------------------------
  // register indices and bus geometry
  // ----------------------------------------
  localparam int          ADDR_W           = 12;
  localparam logic [9:0]  IDX_WAKEUP_CTRL  = 10'h031;
  localparam logic [9:0]  IDX_AMP_CONFIG   = 10'h032;
  localparam logic [9:0]  IDX_AMP_REF      = 10'h033;
  localparam logic [9:0]  IDX_AMP_AVERAGE  = 10'h034;
  localparam logic [9:0]  IDX_AMP_RESULT   = 10'h035;
  localparam logic [9:0]  IDX_PHASE_CONFIG = 10'h036;
  localparam logic [9:0]  IDX_PHASE_REF    = 10'h037;
  localparam logic [9:0]  IDX_PHASE_AVERAGE = 10'h038;
  localparam logic [9:0]  IDX_PHASE_RESULT = 10'h039;
  localparam logic [9:0]  IDX_COMMAND      = 10'h040;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int RANGE_BIT      = 7;
  localparam int TIMEOUT_MSB    = 6;
  localparam int TIMEOUT_LSB    = 4;
  localparam int PERIODIC_BIT   = 3;
  localparam int AMP_CHECK_BIT  = 2;
  localparam int PHASE_CHECK_BIT = 1;
  localparam int CAP_CHECK_BIT  = 0;
  localparam int DELTA_MSB      = 7;
  localparam int DELTA_LSB      = 4;
  localparam int INCLUDE_BIT    = 3;
  localparam int WEIGHT_MSB     = 2;
  localparam int WEIGHT_LSB     = 1;
  localparam int REF_AVG_BIT    = 0;
  localparam int CMD_ENABLE_BIT = 0;
  localparam int CMD_DEFAULT_BIT = 1;

  // ----------------------------------------
  // reset values and timing
  // ----------------------------------------
  localparam logic [7:0] RESET_BYTE       = 8'h00;
  localparam int         CLK_HZ           = 40_000_000;
  localparam int         STEP_LONG_MS     = 100;
  localparam int         STEP_SHORT_MS    = 10;
  localparam int         STEP_LONG_CYCLES = CLK_HZ / 1000 * STEP_LONG_MS;
  localparam int         STEP_SHORT_CYCLES = CLK_HZ / 1000 * STEP_SHORT_MS;
  localparam int         STEP_CNT_W       = 23;

endpackage

//--- core/wdt_wakeup_detect_timer.sv
// wake-up detect timer: periodic timer, measurement triggers, threshold
// compare with fixed or auto-averaged reference, AXI4-Lite register slave
// assumes measurement circuits share clk_in and answer with a one-cycle valid
//
// Functional notes
// - range bit picks base step: 0 gives 100 ms, 1 gives 10 ms
// - period is (timeout field plus one) times base step
// - periodic bit raises an interrupt at every timer expiry
// - amplitude check: measure at expiry, interrupt when difference exceeds threshold
// - phase check: measure at expiry, interrupt when difference exceeds threshold
// - capacitance check: measure at expiry, interrupt when it exceeds its threshold
// - control, configuration and reference registers clear at reset and set-default
// - amplitude configuration upper nibble is the amplitude threshold
// - amplitude include bit folds interrupting measurements into the average
// - weight codes 0 to 3 give averaging weights 4, 8, 16, 32
// - amplitude reference select: 0 written reference, 1 auto-average
// - eight-bit read-write amplitude reference register
// - read-only amplitude auto-average register
// - read-only latest amplitude result register
// - amplitude average and result read zero after reset and set-default
// - phase configuration upper nibble is the phase threshold
// - phase include bit folds interrupting measurements into the average
// - phase reference select: 0 written reference, 1 auto-average
// - eight-bit read-write phase reference register, reset to zero
// - read-only phase auto-average register, zero after reset and set-default
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none

module wdt_wakeup_detect_timer #(
  parameter int STEP_LONG  = wdt_pkg::STEP_LONG_CYCLES,
  parameter int STEP_SHORT = wdt_pkg::STEP_SHORT_CYCLES
) (
  input  wire logic                       clk_in,
  input  wire logic                       rst_n_in,
  input  wire logic [wdt_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic                       s_axi_awvalid_in,
  output logic                            s_axi_awready_out,
  input  wire logic [31:0]                s_axi_wdata_in,
  input  wire logic [3:0]                 s_axi_wstrb_in,
  input  wire logic                       s_axi_wvalid_in,
  output logic                            s_axi_wready_out,
  output logic [1:0]                      s_axi_bresp_out,
  output logic                            s_axi_bvalid_out,
  input  wire logic                       s_axi_bready_in,
  input  wire logic [wdt_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic                       s_axi_arvalid_in,
  output logic                            s_axi_arready_out,
  output logic [31:0]                     s_axi_rdata_out,
  output logic [1:0]                      s_axi_rresp_out,
  output logic                            s_axi_rvalid_out,
  input  wire logic                       s_axi_rready_in,
  output logic                            amp_measure_req_out,
  input  wire logic                       amp_result_valid_in,
  input  wire logic [7:0]                 amp_result_in,
  output logic                            phase_measure_req_out,
  input  wire logic                       phase_result_valid_in,
  input  wire logic [7:0]                 phase_result_in,
  output logic                            cap_measure_req_out,
  input  wire logic                       cap_result_valid_in,
  input  wire logic                       cap_over_threshold_in,
  output logic                            timer_irq_out,
  output logic                            amp_irq_out,
  output logic                            phase_irq_out,
  output logic                            cap_irq_out
);
  import wdt_pkg::*;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
    abs_diff = (a > b) ? 8'(a - b) : 8'(b - a);
  endfunction

  // arithmetic shift keeps the sign so the average can fall as well as rise
  function automatic logic [7:0] avg_step(input logic [7:0] avg, input logic [7:0] val,
                                          input logic [1:0] code);
    logic signed [9:0] delta;
    logic signed [9:0] moved;
    delta = $signed({2'h0, val}) - $signed({2'h0, avg});
    moved = $signed({2'h0, avg}) + (delta >>> (3'(code) + 3'h2));
    avg_step = moved[7:0];
  endfunction

  function automatic logic [9:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = addr[ADDR_W-1:2];
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0]           wakeup_ctrl_reg;
  logic [7:0]           amp_config_reg;
  logic [7:0]           amp_reference_value_reg;
  logic [7:0]           amp_average_reg;
  logic [7:0]           amplitude_result_value_reg;
  logic [7:0]           phase_config_reg;
  logic [7:0]           phase_reference_value_reg;
  logic [7:0]           phase_average_value_reg;
  logic [7:0]           phase_result_reg;
  logic                 timer_enable_reg;
  logic                 set_default;
  logic                 aw_held_reg;
  logic                 w_held_reg;
  logic [ADDR_W-1:0]    aw_addr_reg;
  logic [7:0]           w_data_reg;
  logic                 w_lane0_reg;
  logic                 do_write;
  logic [9:0]           wr_index;
  logic                 wr_ok;
  logic [7:0]           rd_byte;
  logic                 rd_ok;
  logic [STEP_CNT_W-1:0] step_cnt_reg;
  logic [2:0]           steps_done_reg;
  logic                 step_end;
  logic                 expire;
  logic [STEP_CNT_W-1:0] step_last;
  logic [7:0]           amp_ref_sel;
  logic [7:0]           phase_ref_sel;
  logic                 amp_over;
  logic                 phase_over;

  // ----------------------------------------
  // register write path
  // ----------------------------------------
  assign s_axi_awready_out = !aw_held_reg && !s_axi_bvalid_out;
  assign s_axi_wready_out  = !w_held_reg && !s_axi_bvalid_out;
  assign do_write          = aw_held_reg && w_held_reg && !s_axi_bvalid_out;
  assign wr_index          = reg_index(aw_addr_reg);

  always_comb begin
    case (wr_index)
      IDX_WAKEUP_CTRL, IDX_AMP_CONFIG, IDX_AMP_REF,
      IDX_PHASE_CONFIG, IDX_PHASE_REF, IDX_COMMAND: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // set-default is a write-one command, acted on in the cycle of the write
  assign set_default = do_write && wr_ok && w_lane0_reg && (wr_index == IDX_COMMAND)
                       && w_data_reg[CMD_DEFAULT_BIT];

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr_in;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      w_held_reg  <= 1'b0;
      w_data_reg  <= RESET_BYTE;
      w_lane0_reg <= 1'b0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_held_reg  <= 1'b1;
      w_data_reg  <= s_axi_wdata_in[7:0];
      w_lane0_reg <= s_axi_wstrb_in[0];
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // software-written registers; set-default clears them all
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wakeup_ctrl_reg           <= RESET_BYTE;
      amp_config_reg            <= RESET_BYTE;
      amp_reference_value_reg   <= RESET_BYTE;
      phase_config_reg          <= RESET_BYTE;
      phase_reference_value_reg <= RESET_BYTE;
      timer_enable_reg          <= 1'b0;
    end else if (set_default) begin
      wakeup_ctrl_reg           <= RESET_BYTE;
      amp_config_reg            <= RESET_BYTE;
      amp_reference_value_reg   <= RESET_BYTE;
      phase_config_reg          <= RESET_BYTE;
      phase_reference_value_reg <= RESET_BYTE;
      timer_enable_reg          <= 1'b0;
    end else if (do_write && w_lane0_reg) begin
      case (wr_index)
        IDX_WAKEUP_CTRL:  wakeup_ctrl_reg <= w_data_reg;
        IDX_AMP_CONFIG:   amp_config_reg <= w_data_reg;
        IDX_AMP_REF:      amp_reference_value_reg <= w_data_reg;
        IDX_PHASE_CONFIG: phase_config_reg <= w_data_reg;
        IDX_PHASE_REF:    phase_reference_value_reg <= w_data_reg;
        IDX_COMMAND:      timer_enable_reg <= w_data_reg[CMD_ENABLE_BIT];
        default:          timer_enable_reg <= timer_enable_reg;
      endcase
    end
  end

  // ----------------------------------------
  // register read path
  // ----------------------------------------
  // one read at a time: the address is decoded straight off the bus
  assign s_axi_arready_out = !s_axi_rvalid_out;

  always_comb begin
    rd_ok = 1'b1;
    case (reg_index(s_axi_araddr_in))
      IDX_WAKEUP_CTRL:   rd_byte = wakeup_ctrl_reg;
      IDX_AMP_CONFIG:    rd_byte = amp_config_reg;
      IDX_AMP_REF:       rd_byte = amp_reference_value_reg;
      IDX_AMP_AVERAGE:   rd_byte = amp_average_reg;
      IDX_AMP_RESULT:    rd_byte = amplitude_result_value_reg;
      IDX_PHASE_CONFIG:  rd_byte = phase_config_reg;
      IDX_PHASE_REF:     rd_byte = phase_reference_value_reg;
      IDX_PHASE_AVERAGE: rd_byte = phase_average_value_reg;
      IDX_PHASE_RESULT:  rd_byte = phase_result_reg;
      IDX_COMMAND:       rd_byte = {7'h00, timer_enable_reg};
      default: begin
        rd_byte = RESET_BYTE;
        rd_ok   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h0000_0000;
      s_axi_rresp_out  <= RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out  <= {24'h00_0000, rd_byte};
      s_axi_rresp_out  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  // ----------------------------------------
  // wake-up timer
  // ----------------------------------------
  assign step_last = wakeup_ctrl_reg[RANGE_BIT] ? STEP_CNT_W'(STEP_SHORT - 1)
                                                : STEP_CNT_W'(STEP_LONG - 1);
  assign step_end  = timer_enable_reg && (step_cnt_reg >= step_last);
  assign expire    = step_end
                     && (steps_done_reg >= wakeup_ctrl_reg[TIMEOUT_MSB:TIMEOUT_LSB]);

  // a config change mid-period takes effect at once; the >= compares avoid a wrap
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      step_cnt_reg   <= '0;
      steps_done_reg <= 3'h0;
    end else if (!timer_enable_reg || set_default) begin
      step_cnt_reg   <= '0;
      steps_done_reg <= 3'h0;
    end else if (step_end) begin
      step_cnt_reg   <= '0;
      steps_done_reg <= expire ? 3'h0 : 3'(steps_done_reg + 3'h1);
    end else begin
      step_cnt_reg <= STEP_CNT_W'(step_cnt_reg + 1'b1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      timer_irq_out         <= 1'b0;
      amp_measure_req_out   <= 1'b0;
      phase_measure_req_out <= 1'b0;
      cap_measure_req_out   <= 1'b0;
    end else begin
      timer_irq_out         <= expire && wakeup_ctrl_reg[PERIODIC_BIT];
      amp_measure_req_out   <= expire && wakeup_ctrl_reg[AMP_CHECK_BIT];
      phase_measure_req_out <= expire && wakeup_ctrl_reg[PHASE_CHECK_BIT];
      cap_measure_req_out   <= expire && wakeup_ctrl_reg[CAP_CHECK_BIT];
    end
  end

  // ----------------------------------------
  // amplitude channel
  // ----------------------------------------
  assign amp_ref_sel = amp_config_reg[REF_AVG_BIT] ? amp_average_reg
                                                   : amp_reference_value_reg;
  assign amp_over    = abs_diff(amp_result_in, amp_ref_sel)
                       > {4'h0, amp_config_reg[DELTA_MSB:DELTA_LSB]};

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      amplitude_result_value_reg <= RESET_BYTE;
      amp_average_reg            <= RESET_BYTE;
    end else if (set_default) begin
      amplitude_result_value_reg <= RESET_BYTE;
      amp_average_reg            <= RESET_BYTE;
    end else if (amp_result_valid_in) begin
      amplitude_result_value_reg <= amp_result_in;
      if (!amp_over || amp_config_reg[INCLUDE_BIT]) begin
        amp_average_reg <= avg_step(amp_average_reg, amp_result_in,
                                    amp_config_reg[WEIGHT_MSB:WEIGHT_LSB]);
      end
    end
  end

  // ----------------------------------------
  // phase channel
  // ----------------------------------------
  assign phase_ref_sel = phase_config_reg[REF_AVG_BIT] ? phase_average_value_reg
                                                       : phase_reference_value_reg;
  assign phase_over    = abs_diff(phase_result_in, phase_ref_sel)
                         > {4'h0, phase_config_reg[DELTA_MSB:DELTA_LSB]};

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_result_reg        <= RESET_BYTE;
      phase_average_value_reg <= RESET_BYTE;
    end else if (set_default) begin
      phase_result_reg        <= RESET_BYTE;
      phase_average_value_reg <= RESET_BYTE;
    end else if (phase_result_valid_in) begin
      phase_result_reg <= phase_result_in;
      if (!phase_over || phase_config_reg[INCLUDE_BIT]) begin
        phase_average_value_reg <= avg_step(phase_average_value_reg, phase_result_in,
                                            phase_config_reg[WEIGHT_MSB:WEIGHT_LSB]);
      end
    end
  end

  // ----------------------------------------
  // measurement interrupts
  // ----------------------------------------
  // capacitance compare lives in the sensor; only its verdict arrives here
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      amp_irq_out   <= 1'b0;
      phase_irq_out <= 1'b0;
      cap_irq_out   <= 1'b0;
    end else begin
      amp_irq_out   <= amp_result_valid_in && amp_over && !set_default;
      phase_irq_out <= phase_result_valid_in && phase_over && !set_default;
      cap_irq_out   <= cap_result_valid_in && cap_over_threshold_in
                       && wakeup_ctrl_reg[CAP_CHECK_BIT];
    end
  end

endmodule

`default_nettype wire

//--- test/wdt_wakeup_detect_timer_properties.sv
// checker for the wake-up detect timer: bus handshakes and interrupt causes
// assumes it is bound to wdt_wakeup_detect_timer and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module wdt_wakeup_detect_timer_checker (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic        amp_measure_req_out,
  input wire logic        amp_result_valid_in,
  input wire logic        amp_irq_out,
  input wire logic        phase_result_valid_in,
  input wire logic        phase_irq_out,
  input wire logic        cap_result_valid_in,
  input wire logic        cap_over_threshold_in,
  input wire logic        cap_irq_out
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_write_answer: assert property (
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
    |-> ##[1:2] s_axi_bvalid_out) else $error("write response missing");
  a_bvalid_holds: assert property (
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out) else $error("bvalid dropped");
  a_read_answer: assert property (
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out) else $error("read late");
  a_rdata_upper_zero: assert property (
    s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h000000) else $error("rdata wide");
  a_amp_req_pulse: assert property (
    amp_measure_req_out |=> !amp_measure_req_out) else $error("amp request too long");
  a_amp_irq_cause: assert property (
    amp_irq_out |-> $past(amp_result_valid_in)) else $error("amp irq without result");
  a_phase_irq_cause: assert property (
    phase_irq_out |-> $past(phase_result_valid_in)) else $error("phase irq without result");
  a_cap_irq_cause: assert property (
    cap_irq_out |-> $past(cap_result_valid_in) && $past(cap_over_threshold_in))
    else $error("cap irq without verdict");
  c_amp_irq: cover property (amp_irq_out);
  c_phase_irq: cover property (phase_irq_out);
  c_cap_irq: cover property (cap_irq_out);
endmodule

bind wdt_wakeup_detect_timer wdt_wakeup_detect_timer_checker u_wdt_wakeup_detect_timer_checker (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .s_axi_awvalid_in(s_axi_awvalid_in),
  .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in),
  .s_axi_wready_out(s_axi_wready_out), .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_bready_in(s_axi_bready_in), .s_axi_arvalid_in(s_axi_arvalid_in),
  .s_axi_arready_out(s_axi_arready_out), .s_axi_rvalid_out(s_axi_rvalid_out),
  .s_axi_rdata_out(s_axi_rdata_out), .amp_measure_req_out(amp_measure_req_out),
  .amp_result_valid_in(amp_result_valid_in), .amp_irq_out(amp_irq_out),
  .phase_result_valid_in(phase_result_valid_in), .phase_irq_out(phase_irq_out),
  .cap_result_valid_in(cap_result_valid_in), .cap_over_threshold_in(cap_over_threshold_in),
  .cap_irq_out(cap_irq_out));
`default_nettype wire

//--- test/wdt_wakeup_detect_timer_tb.sv
// self-checking bench for the wake-up detect timer
// assumes short step parameters so every period fits in a few dozen cycles
`timescale 1ns/10ps
`default_nettype none
module wdt_wakeup_detect_timer_tb;
  import wdt_pkg::*;
  // ----------------------------------------
  // stimulus and reference state
  // ----------------------------------------
  localparam int SL = 8;
  localparam int SS = 4;
  localparam logic [9:0] RW [5] = '{IDX_WAKEUP_CTRL, IDX_AMP_CONFIG, IDX_AMP_REF,
                                    IDX_PHASE_CONFIG, IDX_PHASE_REF};
  logic        clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic        rready = 0, cv = 0, cov = 0, bvalid, rvalid, awready, wready, arready;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [1:0]  mv = '0, bresp, rresp;
  logic [7:0]  mr = '0;
  logic [7:0]  cfg_m [2] = '{8'h00, 8'h00}, ref_m [2] = '{8'h00, 8'h00};
  logic [7:0]  avg_m [2] = '{8'h00, 8'h00};
  wire  [2:0]  req;
  wire  [3:0]  irq;
  int          failures = 0, checks = 0, cyc = 0;

  always #12.5 clk = ~clk;

  wdt_wakeup_detect_timer #(.STEP_LONG(SL), .STEP_SHORT(SS)) u_wdt_wakeup_detect_timer (
    .clk_in(clk), .rst_n_in(rst_n), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .amp_measure_req_out(req[0]), .amp_result_valid_in(mv[0]), .amp_result_in(mr),
    .phase_measure_req_out(req[1]), .phase_result_valid_in(mv[1]), .phase_result_in(mr),
    .cap_measure_req_out(req[2]), .cap_result_valid_in(cv), .cap_over_threshold_in(cov),
    .timer_irq_out(irq[0]), .amp_irq_out(irq[1]), .phase_irq_out(irq[2]),
    .cap_irq_out(irq[3]));

  // ----------------------------------------
  // tasks: all start and end just after a rising edge
  // ----------------------------------------
  task automatic final_report;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // lb raises bready only after bvalid is seen, so the response must stand a cycle
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er,
                    input bit lb = 1'b0);
    logic ad, wd;
    ad = 0;
    wd = 0;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= !lb;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (awvalid && awready) begin ad = 1; awvalid <= 0; end
      if (wvalid && wready) begin wd = 1; wvalid <= 0; end
    end
    do @(posedge clk); while (!bvalid);
    if (lb) begin
      bready <= 1;
      @(posedge clk);
    end
    bready <= 0;
    chk(bresp, er);
    @(posedge clk);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [7:0] ed, input logic [1:0] er);
    araddr <= {idx, 2'b00};
    arvalid <= 1;
    rready <= 1;
    do @(posedge clk); while (!arready);
    arvalid <= 0;
    do @(posedge clk); while (!rvalid);
    rready <= 0;
    chk(rdata, {24'h000000, ed});
    chk(rresp, er);
    @(posedge clk);
  endtask

  // reference average and threshold verdict are worked out before the pulse
  task automatic send(input int ch, input logic [7:0] v);
    logic [7:0]        r;
    logic signed [9:0] d;
    logic              e;
    r = cfg_m[ch][0] ? avg_m[ch] : ref_m[ch];
    d = $signed({2'b00, v}) - $signed({2'b00, r});
    e = (d < 0 ? -d : d) > $signed({6'h00, cfg_m[ch][7:4]});
    if (!e || cfg_m[ch][3]) begin
      d = $signed({2'b00, v}) - $signed({2'b00, avg_m[ch]});
      d = d >>> (cfg_m[ch][2:1] + 2);
      avg_m[ch] = avg_m[ch] + d[7:0];
    end
    mr <= v;
    mv[ch] <= 1;
    @(posedge clk);
    mv[ch] <= 0;
    #1 chk(irq[ch+1], e);
    @(posedge clk);
  endtask

  task automatic capm(input logic o, input logic e);
    cov <= o;
    cv <= 1;
    @(posedge clk);
    cv <= 0;
    #1 chk(irq[3], e);
    @(posedge clk);
  endtask

  task automatic zeros;
    for (int i = 0; i < 9; i++) rd(IDX_WAKEUP_CTRL + 10'(i), 8'h00, RESP_OKAY);
  endtask

  task automatic t_default;
    wr(IDX_COMMAND, 8'h02, RESP_OKAY);
    zeros();
    rd(IDX_COMMAND, 8'h00, RESP_OKAY);
    cfg_m = '{8'h00, 8'h00};
    ref_m = '{8'h00, 8'h00};
    avg_m = '{8'h00, 8'h00};
  endtask

  task automatic t_regs;
    rd(10'h03A, 8'h00, RESP_SLVERR);
    wr(10'h03A, 8'h11, RESP_SLVERR, 1'b1);
    wr(IDX_AMP_AVERAGE, 8'h5A, RESP_SLVERR);
    rd(IDX_AMP_AVERAGE, 8'h00, RESP_OKAY);
    wr(IDX_AMP_RESULT, 8'h5A, RESP_SLVERR);
    for (int i = 0; i < 5; i++) begin
      wr(RW[i], 8'hA5 ^ 8'(i * 8'h11), RESP_OKAY);
      rd(RW[i], 8'hA5 ^ 8'(i * 8'h11), RESP_OKAY);
    end
  endtask

  task automatic t_timer;
    int n;
    for (int r = 0; r < 2; r++) begin
      for (int t = 0; t < 8; t += 7) begin
        wr(IDX_COMMAND, 8'h00, RESP_OKAY);
        wr(IDX_WAKEUP_CTRL, 8'((r << 7) | (t << 4) | 8), RESP_OKAY);
        wr(IDX_COMMAND, 8'h01, RESP_OKAY);
        do @(posedge clk); while (!irq[0]);
        n = 0;
        do begin @(posedge clk); n++; end while (!irq[0]);
        chk(n, (t + 1) * (r ? SS : SL));
      end
    end
  endtask

  task automatic t_trig;
    int n, m;
    wr(IDX_WAKEUP_CTRL, 8'h87, RESP_OKAY);
    do @(posedge clk); while (!req[0]);
    chk(req, 3'b111);
    n = 0;
    m = 0;
    repeat (3 * SS) begin @(posedge clk); n += irq[0]; m += req[0]; end
    chk(n, 0);
    chk(m, 3);
    capm(1, 1);
    capm(0, 0);
    wr(IDX_WAKEUP_CTRL, 8'h80, RESP_OKAY);
    capm(1, 0);
    n = 0;
    repeat (3 * SS) begin @(posedge clk); n += |req; end
    chk(n, 0);
  endtask

  // same walk for both channels; register block of phase sits four above amplitude
  task automatic t_chan(input int ch);
    logic [9:0] b;
    b = IDX_AMP_CONFIG + 10'(4 * ch);
    ref_m[ch] = 8'h50;
    wr(b + 10'h1, 8'h50, RESP_OKAY);
    cfg_m[ch] = 8'h40;
    wr(b, 8'h40, RESP_OKAY);
    send(ch, 8'h54);
    send(ch, 8'h55);
    send(ch, 8'h4B);
    rd(b + 10'h2, avg_m[ch], RESP_OKAY);
    rd(b + 10'h3, 8'h4B, RESP_OKAY);
    for (int c = 0; c < 4; c++) begin
      cfg_m[ch] = 8'h48 | 8'(c << 1);
      wr(b, cfg_m[ch], RESP_OKAY);
      send(ch, 8'hC0);
      send(ch, 8'h20);
      rd(b + 10'h2, avg_m[ch], RESP_OKAY);
    end
    cfg_m[ch] = 8'h41;
    wr(b, 8'h41, RESP_OKAY);
    send(ch, avg_m[ch] + 8'h04);
    send(ch, avg_m[ch] + 8'h05);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    zeros();
    t_regs();
    t_default();
    t_timer();
    t_trig();
    t_chan(0);
    t_chan(1);
    t_default();
    final_report();
  end
endmodule
`default_nettype wire
